// *** shared/plseq_pkg.sv ***
// plseq_pkg: sizes and reset values for the programmable logic sequencer
package plseq_pkg;
  // ****************************************************************
  // array sizes
  // ****************************************************************
  localparam int NUM_INPUTS   = 16;
  localparam int NUM_STATE    = 6;
  localparam int NUM_OUTPUTS  = 8;
  localparam int NUM_PTERMS   = 48;
  localparam int NUM_REGBITS  = NUM_STATE + NUM_OUTPUTS;
  // and-array columns: inputs, state feedback, complement term
  localparam int NUM_AND_IN   = NUM_INPUTS + NUM_STATE + 1;
  localparam int NUM_LITERALS = 2 * NUM_AND_IN;
  // ****************************************************************
  // reset / preset values and diagnostic high bits
  // ****************************************************************
  localparam logic [NUM_STATE-1:0]   STATE_PRESET = 6'h3f;
  localparam logic [NUM_OUTPUTS-1:0] OUT_PRESET   = 8'hff;
  localparam logic [1:0]             DIAG_HIGH    = 2'h3;
endpackage : plseq_pkg

// *** rtl/plseq_srbit.sv ***
// plseq_srbit: one rising-edge set/reset flip-flop with preset
`timescale 1ns/1ps
module plseq_srbit
  import plseq_pkg::*;
(
  // clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_B_I,
  input  wire logic CE_I,
  // control
  input  wire logic preset_i,
  input  wire logic set_i,
  input  wire logic reset_i,
  // state
  output logic      q_o
);
  // hold on s=r=0; toggle on s=r=1 as a plain s/r latch model choice
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q_o <= 1'b1;
    end else if (CE_I) begin
      // preset inhibits loading but still obeys the freeze
      if (preset_i) begin
        q_o <= 1'b1;
      end else if (set_i && !reset_i) begin
        q_o <= 1'b1;
      end else if (reset_i && !set_i) begin
        q_o <= 1'b0;
      end else if (set_i && reset_i) begin
        q_o <= ~q_o;
      end
    end
  end
endmodule : plseq_srbit

// *** rtl/plseq_top.sv ***
// plseq_top: fuse-programmable mealy logic sequencer core
// Function
// - Mealy sequencer: outputs from state and inputs
// - 48 product terms, 14 set/reset sum pairs
// - six state bits, eight output bits
// - state fed back with 16 inputs
// - complement sum term fed back to array
// - set/reset flops update on rising edge
// - all register bits high at power-up
// - control pin presets, or output enable if fused
// - preset high holds all bits high
// - loading resumes first edge after preset
// - blown and-array link reads as high
// - blown or-array link reads as low
// - diagnostic: state on outputs, top two high
// - output register keeps loading during diagnostic
`timescale 1ns/1ps
module plseq_top
  import plseq_pkg::*;
(
  // clock and reset
  input  wire logic                                CLK_I,
  input  wire logic                                RST_B_I,
  input  wire logic                                CE_I,
  // fuse map, 1 = link intact
  input  wire logic [NUM_PTERMS*NUM_LITERALS-1:0]  AND_FUSE_I,
  input  wire logic [NUM_PTERMS*2*NUM_REGBITS-1:0] OR_FUSE_I,
  input  wire logic [NUM_PTERMS-1:0]               CMP_FUSE_I,
  input  wire logic                                OE_OPTION_I,
  // pins
  input  wire logic [NUM_INPUTS-1:0]               LOGIC_INPUTS_I,
  input  wire logic                                DIAG_ENTRY_I,
  input  wire logic                                PRE_OE_I,
  // outputs
  output logic      [NUM_OUTPUTS-1:0]              REGISTERED_OUTPUTS_O,
  output logic      [NUM_OUTPUTS-1:0]              OUTPUT_EN_O,
  output logic      [NUM_STATE-1:0]                PRESENT_STATE_O
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [NUM_INPUTS-1:0] in_s1_q, in_s2_q;
  logic [1:0]            ctl_s1_q, ctl_s2_q;

  // logic inputs
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else if (CE_I) begin
      in_s1_q <= LOGIC_INPUTS_I;
      in_s2_q <= in_s1_q;
    end
  end

  // diagnostic entry and preset/control pin
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
    end else if (CE_I) begin
      ctl_s1_q <= {DIAG_ENTRY_I, PRE_OE_I};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  logic pin_ctl, diag_on, preset;
  assign pin_ctl = ctl_s2_q[0];
  assign diag_on = ctl_s2_q[1];
  assign preset  = !OE_OPTION_I && pin_ctl;

  // ****************************************************************
  // and array, or array, complement term
  // ****************************************************************
  logic [NUM_STATE-1:0]    present_state_q;
  logic [NUM_OUTPUTS-1:0]  out_q;
  logic [NUM_PTERMS-1:0]   pterm;
  logic                    cmp_term;
  logic [NUM_AND_IN-1:0]   and_in;
  logic [NUM_LITERALS-1:0] lits;
  logic [2*NUM_REGBITS-1:0] sums;

  assign and_in = {cmp_term, present_state_q, in_s2_q};
  assign lits   = {~and_in, and_in};

  genvar p;
  generate
    for (p = 0; p < NUM_PTERMS; p++) begin : g_pt
      // blown link floats high, intact link passes literal
      assign pterm[p] = &(lits |
        ~AND_FUSE_I[p*NUM_LITERALS +: NUM_LITERALS]);
    end
  endgenerate

  // complement term sees and_in but ignores its own column to avoid a loop
  logic [NUM_PTERMS-1:0] pterm_nc;
  logic [NUM_LITERALS-1:0] cmask;
  assign cmask = ~({1'b1, {(NUM_AND_IN-1){1'b0}},
                    1'b1, {(NUM_AND_IN-1){1'b0}}});
  generate
    for (p = 0; p < NUM_PTERMS; p++) begin : g_nc
      assign pterm_nc[p] = &((lits |
        ~AND_FUSE_I[p*NUM_LITERALS +: NUM_LITERALS]) | ~cmask);
      a_and_blown: assert property (@(posedge CLK_I)
        disable iff (!RST_B_I)
        ((AND_FUSE_I[p*NUM_LITERALS +: NUM_LITERALS] & cmask) == '0)
        |-> pterm_nc[p])
        else $error("blown and links not high");
    end
  endgenerate
  assign cmp_term = ~|(pterm_nc & CMP_FUSE_I);

  genvar s;
  generate
    for (s = 0; s < 2*NUM_REGBITS; s++) begin : g_sum
      logic [NUM_PTERMS-1:0] col;
      genvar k;
      for (k = 0; k < NUM_PTERMS; k++) begin : g_col
        assign col[k] = OR_FUSE_I[k*2*NUM_REGBITS + s];
      end
      // blown link floats low
      assign sums[s] = |(pterm & col);
      a_or_blown: assert property (@(posedge CLK_I)
        disable iff (!RST_B_I) (col == '0) |-> !sums[s])
        else $error("blown or links not low");
    end
  endgenerate

  // ****************************************************************
  // set/reset registers: pair s = {set at 2b+1, reset at 2b}
  // ****************************************************************
  logic [NUM_REGBITS-1:0] reg_q;
  genvar b;
  generate
    for (b = 0; b < NUM_REGBITS; b++) begin : g_reg
      plseq_srbit u_bit (
        .CLK_I    (CLK_I),
        .RST_B_I  (RST_B_I),
        .CE_I     (CE_I),
        .preset_i (preset),
        .set_i    (sums[2*b+1]),
        .reset_i  (sums[2*b]),
        .q_o      (reg_q[b])
      );
    end
  endgenerate
  assign present_state_q = reg_q[NUM_STATE-1:0];
  assign out_q           = reg_q[NUM_REGBITS-1:NUM_STATE];

  // ****************************************************************
  // output view and enable
  // ****************************************************************
  logic [NUM_OUTPUTS-1:0] view;
  assign view = diag_on ? {DIAG_HIGH, present_state_q} : out_q;
  assign REGISTERED_OUTPUTS_O = view;
  assign OUTPUT_EN_O = {NUM_OUTPUTS{!(OE_OPTION_I && pin_ctl)}};
  assign PRESENT_STATE_O = present_state_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_power_up_high: assert property (@(posedge CLK_I)
    (!RST_B_I ##1 !RST_B_I) |->
    (reg_q == {OUT_PRESET, STATE_PRESET}))
    else $error("registers not high during reset");
  a_preset_holds_high: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) (preset && CE_I) |=> (reg_q == '1))
    else $error("preset did not force registers high");
  a_diag_view: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) diag_on |->
    (REGISTERED_OUTPUTS_O == {2'h3, present_state_q}))
    else $error("diagnostic view wrong");
  a_diag_keeps_out: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) (diag_on && !CE_I) |=> $stable(out_q))
    else $error("output register changed while frozen");
  a_diag_out_idle: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I)
    (diag_on && !preset && (sums[2*NUM_REGBITS-1:2*NUM_STATE] == '0))
    |=> $stable(out_q))
    else $error("output register moved during diagnostics");
  a_freeze_state: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) !CE_I |=> $stable(reg_q))
    else $error("registers moved while clock enable low");
  a_oe_preset_opt: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) !OE_OPTION_I |-> (OUTPUT_EN_O == '1))
    else $error("outputs disabled in preset option");
  a_oe_level: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) OE_OPTION_I |->
    (OUTPUT_EN_O == {8{!pin_ctl}}))
    else $error("output enable level wrong");
  a_set_loads: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) (CE_I && !preset && sums[1] && !sums[0])
    |=> reg_q[0])
    else $error("set did not load");
  a_reset_loads: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) (CE_I && !preset && sums[0] && !sums[1])
    |=> !reg_q[0])
    else $error("reset did not load");
  a_preset_release: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I)
    ($fell(preset) && CE_I && sums[0] && !sums[1]) |=> !reg_q[0])
    else $error("first edge after preset did not load");
  a_out_reset_loads: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I)
    (CE_I && !preset && sums[2*NUM_REGBITS-2] && !sums[2*NUM_REGBITS-1])
    |=> !reg_q[NUM_REGBITS-1])
    else $error("output bit reset did not load");
  a_cmp_term: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) ((pterm_nc & CMP_FUSE_I) == '0) |-> cmp_term)
    else $error("empty complement term not high");
  a_cmp_low: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) ((pterm_nc & CMP_FUSE_I) != '0) |-> !cmp_term)
    else $error("complement term not low");
  c_preset: cover property (@(posedge CLK_I) preset ##1 !preset);
  c_diag: cover property (@(posedge CLK_I) diag_on);
  c_oe_off: cover property (@(posedge CLK_I) OE_OPTION_I && pin_ctl);
  c_diag_frozen: cover property (@(posedge CLK_I) diag_on && !CE_I);
  c_cmp_low: cover property (@(posedge CLK_I) !cmp_term);
endmodule : plseq_top

// *** sim/plseq_pins.sv ***
// plseq_pins: board side of the eight output pins, pulled up
`timescale 1ns/1ps
module plseq_pins
  import plseq_pkg::*;
(
  // from the sequencer
  input  wire logic [NUM_OUTPUTS-1:0] q_i,
  input  wire logic [NUM_OUTPUTS-1:0] en_i,
  // resolved pin levels
  output logic      [NUM_OUTPUTS-1:0] pin_o
);
  // released pins float to the pull-up level
  always_comb begin
    for (int b = 0; b < NUM_OUTPUTS; b++) begin
      pin_o[b] = en_i[b] ? q_i[b] : 1'b1;
    end
  end
endmodule : plseq_pins

// *** sim/plseq_top_tb.sv ***
// plseq_top_tb: self-checking bench for the logic sequencer
`timescale 1ns/1ps
module plseq_top_tb
  import plseq_pkg::*;
;
  logic                                clk, rst_b, ce, opt, diag, pre;
  logic [NUM_PTERMS*NUM_LITERALS-1:0]  and_f;
  logic [NUM_PTERMS*2*NUM_REGBITS-1:0] or_f;
  logic [NUM_PTERMS-1:0]               cmp_f;
  logic [NUM_INPUTS-1:0]               li;
  logic [NUM_OUTPUTS-1:0]              q, en, pin;
  logic [NUM_STATE-1:0]                st;
  int                                  n_mismatch = 0;
  int                                  checks = 0;

  plseq_top i_plseq_top (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .AND_FUSE_I(and_f), .OR_FUSE_I(or_f), .CMP_FUSE_I(cmp_f),
    .OE_OPTION_I(opt), .LOGIC_INPUTS_I(li), .DIAG_ENTRY_I(diag),
    .PRE_OE_I(pre), .REGISTERED_OUTPUTS_O(q), .OUTPUT_EN_O(en),
    .PRESENT_STATE_O(st));
  plseq_pins i_plseq_pins (.q_i(q), .en_i(en), .pin_o(pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // n edges, then sample settled values
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick

  task automatic conclude();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_reset();
    chk({2'h0, st}, 8'h3f);
    chk(q, 8'hff);
    chk(en, 8'hff);
  endtask : s_reset

  task automatic s_load();
    @(posedge clk) li <= 16'h0002;
    tick(4);
    chk({2'h0, st}, 8'h3e);
    chk(q, 8'h7f);
    @(posedge clk) li <= 16'h0000;
    tick(4);
    chk({2'h0, st}, 8'h3f);
    chk(q, 8'h7f);
    @(posedge clk) li <= 16'h0002;
    tick(4);
  endtask : s_load

  task automatic s_diag();
    @(posedge clk) diag <= 1'b1;
    tick(4);
    chk(q, 8'hfe);
    @(posedge clk) diag <= 1'b0;
    tick(4);
    chk(q, 8'h7f);
  endtask : s_diag

  task automatic s_preset();
    @(posedge clk) pre <= 1'b1;
    tick(4);
    chk({2'h0, st}, 8'h3f);
    tick(3);
    chk(q, 8'hff);
    @(posedge clk) pre <= 1'b0;
    tick(4);
    chk({2'h0, st}, 8'h3e);
  endtask : s_preset

  task automatic s_oe();
    @(posedge clk) opt <= 1'b1;
    pre <= 1'b1;
    tick(4);
    chk(en, 8'h00);
    chk(pin, 8'hff);
    chk({2'h0, st}, 8'h3e);
    @(posedge clk) pre <= 1'b0;
    tick(4);
    chk(en, 8'hff);
    chk(pin, 8'h7f);
  endtask : s_oe

  // diagnostics held across a clock-enable freeze
  task automatic s_freeze();
    @(posedge clk) diag <= 1'b1;
    tick(4);
    @(posedge clk) ce <= 1'b0;
    li <= 16'h0000;
    tick(4);
    chk({2'h0, st}, 8'h3e);
    chk(q, 8'hfe);
    @(posedge clk) ce <= 1'b1;
    tick(4);
    chk(q, 8'hff);
    @(posedge clk) diag <= 1'b0;
    li <= 16'h0002;
    tick(4);
    chk(q, 8'h7f);
  endtask : s_freeze

  // reset asserted and released in mid-run
  task automatic s_rst_mid();
    @(posedge clk) rst_b <= 1'b0;
    tick(1);
    chk({2'h0, st}, 8'h3f);
    chk(q, 8'hff);
    @(posedge clk) rst_b <= 1'b1;
    tick(2);
    chk({2'h0, st}, 8'h3f);
    tick(1);
    chk({2'h0, st}, 8'h3e);
    chk(q, 8'h7f);
  endtask : s_rst_mid

  initial begin
    rst_b = 1'b0; ce = 1'b1; opt = 1'b0; diag = 1'b0; pre = 1'b0;
    li = '0; cmp_f = '0; or_f = '0; and_f = '1;
    and_f[0 +: 46] = '0;
    and_f[1] = 1'b1;
    and_f[92 +: 46] = '0;
    and_f[92 + 22] = 1'b1;
    or_f[0] = 1'b1;
    or_f[26] = 1'b1;
    or_f[2*28 + 1] = 1'b1;
    cmp_f[0] = 1'b1;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    s_reset();
    s_load();
    s_diag();
    s_freeze();
    s_preset();
    s_oe();
    s_rst_mid();
    conclude();
  end
endmodule : plseq_top_tb
